// [src/ccc_clk_cfg.sv]
// Overview of operation
// - rate config byte at 0x33, reset 0x00
// - pll config byte at 0x34, reset 0x40
// - rate code zero means auto detection
// - code 1 is 768000 Hz, given window
// - code 20 is 48000 Hz, given window
// - code 5 is 384000 Hz, given window
// - tolerance bit picks 1% or 5% auto-detect match
// - auto mode accepts only standard table rates
// - reserved bit 0 reads zero, written zero
// - pll off bit disables pll; else custom mode or load request enables it
// - fractional permit bit gates fractional pll
// - three-bit field chooses pll reference source
// - edge bit picks rising or falling check
module ccc_clk_cfg #(
  parameter int unsigned GATE_LEN = ccc_pkg::GATE_CYCLES
) (
  input  wire logic                     clk_i,
  input  wire logic                     sys_rst_i,
  input  ccc_pkg::ccc_reg_req_type      reg_req_i,
  output logic [7:0]                    reg_rdata_o,
  output logic                          reg_rvalid_o,
  input  wire logic                     sec_frame_sync_i,
  input  wire logic                     custom_clk_mode_i,
  input  wire logic                     pll_load_req_i,
  output logic                          pll_enable_o,
  output logic                          pll_frac_en_o,
  output logic [2:0]                    ref_src_o,
  output logic                          ratio_edge_fall_o,
  output logic [5:0]                    rate_code_o,
  output logic                          rate_ok_o,
  output logic [23:0]                   meas_hz_o
);
  import ccc_pkg::*;

  ccc_rate_cfg_type   rate_q, rate_d;
  ccc_pll_cfg_type    pll_q, pll_d;
  logic [7:0]         rdata_q, rdata_d;
  logic               rvalid_q, rvalid_d;
  logic [2:0]         fs_sync_q;
  logic               fs_lvl_q, fs_lvl_d;
  ccc_state_type      st_q, st_d;
  logic [23:0]        gate_q, gate_d;
  logic [15:0]        edges_q, edges_d;
  logic [23:0]        meas_q, meas_d;
  logic [5:0]         scan_q, scan_d;
  logic [5:0]         code_q, code_d;
  logic               ok_q, ok_d;
  logic               pll_en_q, pll_en_d, frac_en_q, frac_en_d;
  ccc_rate_entry_type entry;
  logic               auto_mode;
  logic               gate_end;
  logic               fs_rise;
  logic [31:0]        meas32, typ32, diff32, tol_pct;
  logic               in_window, tol_match;

  default clocking @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);
  ccc_rate_rom u_rom (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .code_i    (scan_q),
    .entry_o   (entry)
  );

  // register port: writes store, reads answer one cycle later
  always_comb
  begin
    rate_d   = rate_q;
    pll_d    = pll_q;
    rdata_d  = rdata_q;
    rvalid_d = 1'b0;
    pll_en_d  = !pll_q.pll_off &&
                (custom_clk_mode_i || pll_load_req_i);
    frac_en_d = pll_en_d && pll_q.frac_permit;
    if (reg_req_i.wr)
    begin
      case (reg_req_i.addr)
        RATE_CFG_ADDR:
        begin
          rate_d      = reg_req_i.wdata;
          rate_d.rsvd = 1'b0;
        end
        PLL_CFG_ADDR:
        begin
          pll_d      = reg_req_i.wdata;
          pll_d.rsvd = 2'b00;
        end
        default: rate_d = rate_q;
      endcase
    end
    if (reg_req_i.rd)
    begin
      rvalid_d = 1'b1;
      case (reg_req_i.addr)
        RATE_CFG_ADDR: rdata_d = rate_q;
        PLL_CFG_ADDR:  rdata_d = pll_q;
        default:       rdata_d = RD_UNMAPPED;
      endcase
    end
  end
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      rate_q   <= RATE_CFG_RST;
      pll_q    <= PLL_CFG_RST;
      rdata_q  <= RD_UNMAPPED;
      rvalid_q <= 1'b0;
      pll_en_q  <= 1'b0;
      frac_en_q <= 1'b0;
    end
    else
    begin
      rate_q   <= rate_d;
      pll_q    <= pll_d;
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
      pll_en_q  <= pll_en_d;
      frac_en_q <= frac_en_d;
    end
  end
  assign auto_mode = (rate_q.code == RATE_AUTO);
  assign gate_end  = (gate_q == 24'(GATE_LEN - 1));
  assign fs_rise   = (fs_sync_q[1] == fs_sync_q[2]) && fs_sync_q[2] &&
                     !fs_lvl_q;
  assign meas32    = {8'h00, meas_q};
  assign typ32     = {12'h000, entry.typ};
  assign diff32    = (meas32 > typ32) ? (meas32 - typ32) : (typ32 - meas32);
  assign tol_pct   = rate_q.tol_wide ? TOL_WIDE_PCT : TOL_TIGHT_PCT;
  assign in_window = (entry.typ != 20'h00000) &&
                     (meas32 >= {12'h000, entry.lo}) &&
                     (meas32 <= {12'h000, entry.hi});
  // only table entries can match, so a rate locks only if it lies within the tolerance of a table rate
  assign tol_match = (entry.typ != 20'h00000) &&
                     (32'(diff32 * PCT_SCALE) <= 32'(typ32 * tol_pct));
  // frame sync count over a fixed gate, then a table look-up
  always_comb
  begin
    fs_lvl_d = fs_lvl_q;
    st_d     = st_q;
    gate_d   = gate_q;
    edges_d  = edges_q;
    meas_d   = meas_q;
    scan_d   = scan_q;
    code_d   = code_q;
    ok_d     = ok_q;
    if (fs_sync_q[1] == fs_sync_q[2])
      fs_lvl_d = fs_sync_q[2];
    case (st_q)
      ST_MEAS:
      begin
        gate_d = 24'(gate_q + 24'h000001);
        if (fs_rise)
          edges_d = 16'(edges_q + 16'h0001);
        if (gate_end)
        begin
          gate_d  = 24'h000000;
          edges_d = 16'h0000;
          meas_d  = 24'(edges_q * HZ_PER_EDGE);
          scan_d  = auto_mode ? RATE_FIRST : rate_q.code;
          st_d    = ST_LOOK;
        end
      end
      ST_LOOK: st_d = ST_CHECK;
      ST_CHECK:
      begin
        st_d = ST_MEAS;
        if (!auto_mode)
        begin
          code_d = scan_q;
          ok_d   = in_window;
        end
        else if (tol_match)
        begin
          code_d = scan_q;
          ok_d   = 1'b1;
        end
        else if (scan_q == RATE_LAST)
        begin
          code_d = RATE_AUTO;
          ok_d   = 1'b0;
        end
        else
        begin
          scan_d = 6'(scan_q + 6'h01);
          st_d   = ST_LOOK;
        end
      end
      default: st_d = ST_MEAS;
    endcase
  end
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      fs_sync_q <= 3'h0;
      fs_lvl_q  <= 1'b0;
      st_q      <= ST_MEAS;
      gate_q    <= 24'h000000;
      edges_q   <= 16'h0000;
      meas_q    <= 24'h000000;
      scan_q    <= RATE_AUTO;
      code_q    <= RATE_AUTO;
      ok_q      <= 1'b0;
    end
    else
    begin
      fs_sync_q <= {fs_sync_q[1:0], sec_frame_sync_i};
      fs_lvl_q  <= fs_lvl_d;
      st_q      <= st_d;
      gate_q    <= gate_d;
      edges_q   <= edges_d;
      meas_q    <= meas_d;
      scan_q    <= scan_d;
      code_q    <= code_d;
      ok_q      <= ok_d;
    end
  end

  assign reg_rdata_o       = rdata_q;
  assign reg_rvalid_o      = rvalid_q;
  assign pll_enable_o      = pll_en_q;
  assign pll_frac_en_o     = frac_en_q;
  assign ref_src_o         = pll_q.ref_src;
  assign ratio_edge_fall_o = pll_q.ratio_fall;
  assign rate_code_o       = code_q;
  assign rate_ok_o         = ok_q;
  assign meas_hz_o         = meas_q;

  sequence s_rd_rate;
    reg_req_i.rd && reg_req_i.addr == RATE_CFG_ADDR;
  endsequence
  sequence s_wr_pll;
    reg_req_i.wr && reg_req_i.addr == PLL_CFG_ADDR;
  endsequence
  property p_rd_rate;
    s_rd_rate |=> reg_rvalid_o &&
      reg_rdata_o[7:1] == {$past(rate_q.code), $past(rate_q.tol_wide)};
  endproperty
  a_rd_rate: assert property (p_rd_rate)
    else $error("rate config read wrong");
  property p_rsvd0;
    s_rd_rate |=> reg_rdata_o[0] == 1'b0;
  endproperty
  a_rsvd0: assert property (p_rsvd0)
    else $error("reserved bit 0 not zero");
  property p_reset_vals;
    $fell(sys_rst_i) |-> pll_q == PLL_CFG_RST && rate_q == RATE_CFG_RST;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("config reset values wrong");
  property p_pll_rsvd;
    reg_req_i.rd && reg_req_i.addr == PLL_CFG_ADDR |=>
      reg_rvalid_o && reg_rdata_o[5:4] == 2'b00;
  endproperty
  a_pll_rsvd: assert property (p_pll_rsvd)
    else $error("pll reserved bits not zero");
  property p_auto_start;
    st_q == ST_MEAS && gate_end && auto_mode |=>
      scan_q == RATE_FIRST ##1 st_q == ST_CHECK;
  endproperty
  a_auto_start: assert property (p_auto_start)
    else $error("auto scan did not start at code 1");
  property p_tol_match;
    st_q == ST_CHECK && auto_mode && tol_match |=>
      rate_ok_o && rate_code_o == $past(scan_q);
  endproperty
  a_tol_match: assert property (p_tol_match)
    else $error("tolerance match not taken");
  property p_reject;
    st_q == ST_CHECK && auto_mode && !tol_match && scan_q == RATE_LAST |=>
      !rate_ok_o && rate_code_o == RATE_AUTO;
  endproperty
  a_reject: assert property (p_reject)
    else $error("nonstandard rate not rejected");
  property p_pll_off;
    pll_q.pll_off |=> !pll_enable_o && !pll_frac_en_o;
  endproperty
  a_pll_off: assert property (p_pll_off)
    else $error("pll not disabled");
  property p_frac;
    !pll_q.frac_permit |=> !pll_frac_en_o;
  endproperty
  a_frac: assert property (p_frac)
    else $error("fractional mode not forbidden");
  property p_src;
    s_wr_pll |=> ref_src_o == $past(reg_req_i.wdata[3:1]);
  endproperty
  a_src: assert property (p_src)
    else $error("reference source not taken");
  property p_edge;
    s_wr_pll |=> ratio_edge_fall_o == $past(reg_req_i.wdata[0]);
  endproperty
  a_edge: assert property (p_edge)
    else $error("ratio edge not taken");
endmodule

// [common/ccc_pkg.sv]
package ccc_pkg;

  localparam logic [7:0] RATE_CFG_ADDR = 8'h33;
  localparam logic [7:0] PLL_CFG_ADDR  = 8'h34;
  localparam logic [7:0] RATE_CFG_RST  = 8'h00;
  localparam logic [7:0] PLL_CFG_RST   = 8'h40;
  localparam logic [7:0] RD_UNMAPPED   = 8'h00;

  localparam logic [5:0] RATE_AUTO  = 6'h00;
  localparam logic [5:0] RATE_FIRST = 6'h01;
  localparam logic [5:0] RATE_LAST  = 6'h28;

  // reference source codes
  localparam logic [2:0] REF_PRI_BCLK  = 3'h0;
  localparam logic [2:0] REF_PRI_FRAME_SYNC = 3'h1;
  localparam logic [2:0] REF_SEC_BCLK  = 3'h2;
  localparam logic [2:0] REF_SEC_FRAME_SYNC = 3'h3;
  localparam logic [2:0] REF_FIXED     = 3'h4;
  localparam logic [2:0] REF_OSC       = 3'h5;

  localparam int CLK_HZ       = 10_000_000;
  localparam int GATE_TIME_MS = 10;
  localparam int GATE_CYCLES  = CLK_HZ / 1000 * GATE_TIME_MS;
  localparam int HZ_PER_EDGE  = 1000 / GATE_TIME_MS;

  localparam logic [31:0] TOL_TIGHT_PCT = 32'h1;
  localparam logic [31:0] TOL_WIDE_PCT  = 32'h5;
  localparam logic [31:0] PCT_SCALE     = 32'h64;

  typedef struct packed {
    logic [5:0] code;
    logic       tol_wide;
    logic       rsvd;
  } ccc_rate_cfg_type;

  typedef struct packed {
    logic       pll_off;
    logic       frac_permit;
    logic [1:0] rsvd;
    logic [2:0] ref_src;
    logic       ratio_fall;
  } ccc_pll_cfg_type;

  typedef struct packed {
    logic [19:0] typ;
    logic [19:0] lo;
    logic [19:0] hi;
  } ccc_rate_entry_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ccc_reg_req_type;

  typedef enum logic [2:0] {
    ST_MEAS  = 3'b001,
    ST_LOOK  = 3'b010,
    ST_CHECK = 3'b100
  } ccc_state_type;

endpackage

// [src/ccc_rate_rom.sv]
module ccc_rate_rom (
  input  wire logic                        clk_i,
  input  wire logic                        sys_rst_i,
  input  wire logic [5:0]                  code_i,
  output ccc_pkg::ccc_rate_entry_type      entry_o
);
  import ccc_pkg::*;

  ccc_rate_entry_type entry_d;
  ccc_rate_entry_type entry_q;

  function automatic ccc_rate_entry_type ent(input int t, input int l,
                                             input int h);
    ent = {20'(t), 20'(l), 20'(h)};
  endfunction

  // typical rate and accepted window per code; reserved codes are all zero
  always_comb
  begin
    case (code_i)
      6'h01: entry_d = ent(768000, 670320, 791040);
      6'h02: entry_d = ent(614400, 536256, 632832);
      6'h03: entry_d = ent(512000, 446880, 527360);
      6'h04: entry_d = ent(438857, 383040, 452022);
      6'h05: entry_d = ent(384000, 335160, 395520);
      6'h06: entry_d = ent(341333, 297920, 351573);
      6'h07: entry_d = ent(307200, 268128, 316416);
      6'h08: entry_d = ent(256000, 223440, 263680);
      6'h09: entry_d = ent(219429, 191520, 226011);
      6'h0a: entry_d = ent(192000, 167580, 197760);
      6'h0b: entry_d = ent(170667, 148960, 175786);
      6'h0c: entry_d = ent(153600, 134064, 158208);
      6'h0d: entry_d = ent(128000, 111720, 131840);
      6'h0e: entry_d = ent(109714, 95760, 113005);
      6'h0f: entry_d = ent(96000, 83790, 98880);
      6'h10: entry_d = ent(85333, 74480, 87893);
      6'h11: entry_d = ent(76800, 67032, 79104);
      6'h12: entry_d = ent(64000, 55860, 65920);
      6'h13: entry_d = ent(54857, 47880, 56502);
      6'h14: entry_d = ent(48000, 41895, 49440);
      6'h15: entry_d = ent(42667, 37240, 43946);
      6'h16: entry_d = ent(38400, 33516, 39552);
      6'h17: entry_d = ent(32000, 27930, 32960);
      6'h18: entry_d = ent(27429, 23940, 28251);
      6'h19: entry_d = ent(24000, 20947, 24720);
      6'h1a: entry_d = ent(21333, 18620, 21973);
      6'h1b: entry_d = ent(19200, 16758, 19776);
      6'h1c: entry_d = ent(16000, 13955, 16480);
      6'h1d: entry_d = ent(13714, 11970, 14125);
      6'h1e: entry_d = ent(12000, 10473, 12360);
      6'h1f: entry_d = ent(10667, 9310, 10986);
      6'h20: entry_d = ent(9600, 8379, 9888);
      6'h21: entry_d = ent(8000, 6982, 8240);
      6'h22: entry_d = ent(6857, 5985, 7062);
      6'h23: entry_d = ent(6000, 5236, 6180);
      6'h24: entry_d = ent(5333, 4655, 5493);
      6'h25: entry_d = ent(4800, 3491, 4120);
      6'h27: entry_d = ent(3429, 2992, 3531);
      6'h28: entry_d = ent(3000, 2618, 3090);
      default: entry_d = ent(0, 0, 0);
    endcase
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      entry_q <= '0;
    else
      entry_q <= entry_d;
  end

  assign entry_o = entry_q;

  property p_code1;
    @(posedge clk_i) disable iff (sys_rst_i)
    code_i == 6'h01 |=> entry_o == ent(768000, 670320, 791040);
  endproperty
  a_code1: assert property (p_code1)
    else $error("code 1 entry wrong");

  property p_code20;
    @(posedge clk_i) disable iff (sys_rst_i)
    code_i == 6'h14 |=> entry_o.typ == 20'(48000) &&
                        entry_o.lo == 20'(41895) && entry_o.hi == 20'(49440);
  endproperty
  a_code20: assert property (p_code20)
    else $error("code 20 entry wrong");

  property p_code5;
    @(posedge clk_i) disable iff (sys_rst_i)
    code_i == 6'h05 |=> entry_o == ent(384000, 335160, 395520);
  endproperty
  a_code5: assert property (p_code5)
    else $error("code 5 entry wrong");

endmodule

// [bench/ccc_clk_cfg_bench.sv]
module ccc_clk_cfg_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import ccc_pkg::*;

  localparam int GATE = 4000;
  localparam int LIMIT = 72000;

  logic             clk_i = 1'b0;
  logic             sys_rst_i = 1'b1;
  ccc_reg_req_type  reg_req = '0;
  logic [7:0]       reg_rdata;
  logic             reg_rvalid;
  logic             sec_fs = 1'b0;
  logic             custom_mode = 1'b0;
  logic             load_req = 1'b0;
  logic             pll_en;
  logic             frac_en;
  logic [2:0]       ref_src;
  logic             edge_fall;
  logic [5:0]       rate_code;
  logic             rate_ok;
  logic [23:0]      meas_hz;
  int               miscompares = 0;
  int               n_compared = 0;
  int               cycles = 0;
  int               fs_half = 0;
  int               fs_acc = 0;

  ccc_clk_cfg #(
    .GATE_LEN(GATE)
  ) ccc_clk_cfg_i (
    .clk_i             (clk_i),
    .sys_rst_i         (sys_rst_i),
    .reg_req_i         (reg_req),
    .reg_rdata_o       (reg_rdata),
    .reg_rvalid_o      (reg_rvalid),
    .sec_frame_sync_i  (sec_fs),
    .custom_clk_mode_i (custom_mode),
    .pll_load_req_i    (load_req),
    .pll_enable_o      (pll_en),
    .pll_frac_en_o     (frac_en),
    .ref_src_o         (ref_src),
    .ratio_edge_fall_o (edge_fall),
    .rate_code_o       (rate_code),
    .rate_ok_o         (rate_ok),
    .meas_hz_o         (meas_hz)
  );

  initial
  begin
    forever #50 clk_i = ~clk_i;
  end

  // frame sync source, scaled so that the short gate sees audio-like counts;
  // toggles just after a clock edge, spaced fs_half ns apart on average
  always @(posedge clk_i)
  begin
    #1;
    if (fs_half == 0)
      sec_fs = 1'b0;
    else if (fs_acc + 100 >= fs_half)
    begin
      fs_acc = fs_acc + 100 - fs_half;
      sec_fs = ~sec_fs;
    end
    else
      fs_acc = fs_acc + 100;
  end

  task automatic stop_test;
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      miscompares++;
      stop_test();
    end
  end

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      miscompares++;
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1 reg_req = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
    #1 reg_req = '0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    #1 reg_req = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    #1 reg_req = '0;
    chk({23'h0, reg_rvalid}, 24'h1);
    chk({16'h0, reg_rdata}, {16'h0, exp});
  endtask

  // retune the source, program the rate byte, then wait out two gates
  task automatic measure(input int half, input logic [7:0] cfg,
                         input logic [5:0] code, input logic ok);
    fs_half = half;
    wr_reg(8'h33, cfg);
    repeat (2 * GATE + 300) @(posedge clk_i);
    #1;
    chk({18'h0, rate_code}, {18'h0, code});
    chk({23'h0, rate_ok}, {23'h0, ok});
  endtask

  task automatic pll_case(input logic off, input logic cm, input logic ld,
                          input logic permit);
    @(posedge clk_i);
    #1 custom_mode = cm;
    load_req = ld;
    wr_reg(8'h34, {off, permit, 6'h00});
    repeat (4) @(posedge clk_i);
    #1;
  endtask

  initial
  begin
    repeat (20) @(posedge clk_i);
    #1 sys_rst_i = 1'b0;

    rd_chk(8'h33, 8'h00);
    rd_chk(8'h34, 8'h40);
    $display("test reset_values done");

    wr_reg(8'h33, 8'hfe);
    rd_chk(8'h33, 8'hfe);
    wr_reg(8'h34, 8'hcf);
    rd_chk(8'h34, 8'hcf);
    wr_reg(8'h35, 8'h5a);
    rd_chk(8'h35, 8'h00);
    rd_chk(8'h34, 8'hcf);
    rd_chk(8'h33, 8'hfe);
    wr_reg(8'h33, 8'h00);
    $display("test reserved_and_unmapped done");

    for (int s = 0; s < 8; s++)
    begin
      wr_reg(8'h34, {4'h4, s[2:0], ~s[0]});
      repeat (2) @(posedge clk_i);
      #1;
      chk({21'h0, ref_src}, {21'h0, s[2:0]});
      chk({23'h0, edge_fall}, {23'h0, ~s[0]});
    end
    $display("test source_select done");

    for (int i = 0; i < 8; i++)
    begin
      pll_case(i[2], i[1], i[0], 1'b1);
      chk({23'h0, pll_en}, {23'h0, ~i[2] & (i[1] | i[0])});
      chk({23'h0, frac_en}, {23'h0, ~i[2] & (i[1] | i[0])});
    end
    pll_case(1'b0, 1'b1, 1'b0, 1'b0);
    chk({23'h0, pll_en}, 24'h1);
    chk({23'h0, frac_en}, 24'h0);
    $display("test pll_control done");

    measure(417, 8'h00, 6'd20, 1'b1);
    chk({23'h0, meas_hz inside {[24'd47900:24'd48000]}}, 24'h1);
    measure(429, 8'h00, 6'd0, 1'b0);
    measure(429, 8'h02, 6'd20, 1'b1);
    measure(444, 8'h02, 6'd0, 1'b0);
    $display("test auto_detect done");

    measure(417, 8'h50, 6'd20, 1'b1);
    measure(417, 8'h14, 6'd5, 1'b0);
    measure(417, 8'h04, 6'd1, 1'b0);
    $display("test programmed_rate done");

    stop_test();
  end

endmodule
